// *** rtl/rfcfs_pkg.sv ***
// ==========================================================
// Constants of the channel and reference-clock decoder
package rfcfs_pkg;
    localparam int           REF_FREQ_MHZ      = 16;
    localparam int           ADDR_W            = 6;
    localparam int           DATA_W            = 8;
    localparam int           FREQ_W            = 14;
    localparam int           TRIM_CAP_W        = 13;

    typedef logic [ADDR_W-1:0] rfcfs_addr_t;
    typedef logic [DATA_W-1:0] rfcfs_data_t;
    typedef logic [FREQ_W-1:0] rfcfs_freq_t;

    // ==========================================================
    // Register offsets
    localparam rfcfs_addr_t  ADDR_CHANNEL_CCA  = 6'h08;
    localparam rfcfs_addr_t  ADDR_JITTER_CTRL  = 6'h0C;
    localparam rfcfs_addr_t  ADDR_OSC_CTRL     = 6'h12;
    localparam rfcfs_addr_t  ADDR_SYNTH_NUMBER = 6'h13;
    localparam rfcfs_addr_t  ADDR_SYNTH_BAND   = 6'h14;
    localparam rfcfs_addr_t  ADDR_STATUS       = 6'h15;
    localparam rfcfs_addr_t  ADDR_FREQ_LO      = 6'h16;
    localparam rfcfs_addr_t  ADDR_FREQ_HI      = 6'h17;

    // ==========================================================
    // Field positions and reset values
    localparam int           STD_CHAN_MSB      = 4;
    localparam int           TRIM_MSB          = 3;
    localparam int           BAND_MSB          = 2;
    localparam int           JITTER_BIT        = 0;
    localparam int           INVALID_BIT       = 0;
    localparam rfcfs_data_t  RESET_REG         = 8'h00;

    typedef enum logic [2:0] {
        BAND_STD     = 3'h0,
        BAND_FINE_LO = 3'h1,
        BAND_FINE_MD = 3'h2,
        BAND_FINE_HI = 3'h3,
        BAND_COARSE1 = 3'h4,
        BAND_COARSE2 = 3'h5,
        BAND_FINE_NA = 3'h6,
        BAND_RSVD    = 3'h7
    } rfcfs_band_t;

    // ==========================================================
    // Carrier figures in 100 kHz units
    localparam rfcfs_freq_t  F_EU              = 14'h21EB; // 868.3 MHz
    localparam rfcfs_freq_t  F_NA_BASE         = 14'h2364; // 906 MHz
    localparam rfcfs_freq_t  F_NA_STEP         = 14'h0014; // 2 MHz
    localparam rfcfs_freq_t  F_BAND1           = 14'h1E0A; // 769.0 MHz
    localparam rfcfs_freq_t  F_BAND2           = 14'h217A; // 857.0 MHz
    localparam rfcfs_freq_t  F_BAND3           = 14'h2346; // 903.0 MHz
    localparam rfcfs_freq_t  F_BAND4           = 14'h1E0A; // 769 MHz
    localparam rfcfs_freq_t  F_BAND5           = 14'h208A; // 833 MHz
    localparam rfcfs_freq_t  F_BAND6           = 14'h233C; // 902.0 MHz
    localparam rfcfs_freq_t  F_COARSE_STEP     = 14'h000A; // 1 MHz
    localparam logic [4:0]   STD_CHAN_MAX      = 5'h0A;
    localparam logic [7:0]   BAND4_NUM_MAX     = 8'h5E;
    localparam logic [7:0]   BAND5_NUM_MAX     = 8'h66;
    localparam logic [TRIM_CAP_W-1:0] TRIM_STEP_FF = 13'h012C; // 0.3 pF
endpackage : rfcfs_pkg

// *** rtl/rfcfs_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Settings in, decoded carrier out
interface rfcfs_if;
    import rfcfs_pkg::*;
    logic [2:0]  band;
    logic [7:0]  number;
    logic [4:0]  std_chan;
    rfcfs_freq_t freq;
    logic        valid;
    modport dec  (input band, input number, input std_chan, output freq, output valid);
    modport user (output band, output number, output std_chan, input freq, input valid);
endinterface : rfcfs_if
`default_nettype wire

// *** rtl/rfcfs_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Combinational band and channel decoder
module rfcfs_decode
    import rfcfs_pkg::*;
(
    rfcfs_if.dec ifc
);
    rfcfs_freq_t k14;
    rfcfs_freq_t n14;

    assign k14 = FREQ_W'(ifc.std_chan);
    assign n14 = FREQ_W'(ifc.number);

    always_comb
    begin
        ifc.freq  = '0;
        ifc.valid = 1'b1;
        case (rfcfs_band_t'(ifc.band))
            BAND_STD: // RQ5
            begin
                // Channel number is not looked at in this band
                if (ifc.std_chan == 5'h00)
                    ifc.freq = F_EU; // RQ6
                else if (ifc.std_chan <= STD_CHAN_MAX)
                    ifc.freq = F_NA_BASE + F_NA_STEP * (k14 - 14'h0001); // RQ7
                else
                    ifc.valid = 1'b0; // RQ15
            end
            BAND_FINE_LO: ifc.freq = F_BAND1 + n14; // RQ8
            BAND_FINE_MD: ifc.freq = F_BAND2 + n14; // RQ9
            BAND_FINE_HI: ifc.freq = F_BAND3 + n14; // RQ10
            BAND_COARSE1:
            begin
                ifc.freq  = F_BAND4 + F_COARSE_STEP * n14;
                ifc.valid = (ifc.number <= BAND4_NUM_MAX); // RQ11
            end
            BAND_COARSE2:
            begin
                ifc.freq  = F_BAND5 + F_COARSE_STEP * n14;
                ifc.valid = (ifc.number <= BAND5_NUM_MAX); // RQ12
            end
            BAND_FINE_NA: ifc.freq = F_BAND6 + n14; // RQ13
            default:      ifc.valid = 1'b0; // RQ16
        endcase
    end
endmodule : rfcfs_decode
`default_nettype wire

// *** rtl/rfcfs_top.sv ***
// Behaviour
// (RQ1) Every generated frequency setting is clocked from the one 16 MHz reference clock.
// (RQ2) The trim code selects 0 to 4.5 pF of added load in 0.3 pF steps, code times 0.3 pF.
// (RQ3) Software loads the factory trim value from user storage into the oscillator register at start-up.
// (RQ4) Jitter enable reaches receiver logic and all I/O including the clock output, never the synthesizer.
// (RQ5) In band 0 the channel number is ignored and the standard channel picks the carrier.
// (RQ6) Band 0 with standard channel 0 gives 868.3 MHz.
// (RQ7) Band 0 with standard channel k from 1 to 10 gives 906 MHz plus 2 MHz times (k-1).
// (RQ8) Band 1 gives 769.0 MHz plus 0.1 MHz per channel number, 0x00 to 0xFF.
// (RQ9) Band 2 gives 857.0 MHz plus 0.1 MHz per channel number, 0x00 to 0xFF.
// (RQ10) Band 3 gives 903.0 MHz plus 0.1 MHz per channel number, 0x00 to 0xFF.
// (RQ11) Band 4 gives 769 MHz plus 1 MHz per channel number, valid 0x00 to 0x5E.
// (RQ12) Band 5 gives 833 MHz plus 1 MHz per channel number, valid 0x00 to 0x66.
// (RQ13) Band 6 gives 902.0 MHz plus 0.1 MHz per channel number, 0x00 to 0xFF.
// (RQ14) The standard channel lives in bits 4:0 of the channel/CCA register at 0x08.
// (RQ15) Standard channels 0x0B and above are reserved with no carrier.
// (RQ16) Band 7, out-of-range numbers and reserved channels raise the invalid flag and hold the old carrier.
// (RQ17) The carrier leaves as a registered count of 100 kHz units, cleared by reset.
`timescale 1ns/1ps
`default_nettype none
module rfcfs_top
    import rfcfs_pkg::*;
(
    input  wire logic                          CLK,
    input  wire logic                          RST,
    input  wire logic                          CE,
    input  wire rfcfs_pkg::rfcfs_addr_t        REG_ADDR,
    input  wire rfcfs_pkg::rfcfs_data_t        REG_WDATA,
    input  wire logic                          REG_WE,
    input  wire logic                          REG_RE,
    output var  rfcfs_pkg::rfcfs_data_t        REG_RDATA,
    output var  rfcfs_pkg::rfcfs_freq_t        FREQ_100KHZ,
    output var  logic                          FREQ_INVALID,
    output var  logic [rfcfs_pkg::TRIM_CAP_W-1:0] TRIM_CAP_FF,
    output var  logic                          RX_JITTER_EN,
    output var  logic                          IO_JITTER_EN
);
    import rfcfs_pkg::*;

    rfcfs_data_t channel_cca_control;
    rfcfs_data_t oscillator_control_reg;
    rfcfs_data_t synth_number_reg;
    rfcfs_data_t synth_band_reg;
    rfcfs_data_t jitter_control;
    rfcfs_data_t next_rdata;
    logic        wr_ok;

    rfcfs_if dec_if ();

    assign wr_ok = CE && REG_WE;

    // ==========================================================
    // Register file
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            channel_cca_control    <= RESET_REG;
            oscillator_control_reg <= RESET_REG;
            synth_number_reg       <= RESET_REG;
            synth_band_reg         <= RESET_REG;
            jitter_control         <= RESET_REG;
        end
        else if (wr_ok)
        begin
            case (REG_ADDR)
                ADDR_CHANNEL_CCA:  channel_cca_control    <= REG_WDATA; // RQ14
                ADDR_OSC_CTRL:     oscillator_control_reg <= REG_WDATA;
                ADDR_SYNTH_NUMBER: synth_number_reg       <= REG_WDATA;
                ADDR_SYNTH_BAND:   synth_band_reg         <= REG_WDATA;
                ADDR_JITTER_CTRL:  jitter_control         <= REG_WDATA;
                default:           ;
            endcase
        end
    end

    // Unused upper bits of the band register read back as zero
    always_comb
    begin
        case (REG_ADDR)
            ADDR_CHANNEL_CCA:  next_rdata = channel_cca_control;
            ADDR_OSC_CTRL:     next_rdata = oscillator_control_reg;
            ADDR_SYNTH_NUMBER: next_rdata = synth_number_reg;
            ADDR_SYNTH_BAND:   next_rdata = {5'h00, synth_band_reg[BAND_MSB:0]};
            ADDR_JITTER_CTRL:  next_rdata = {7'h00, jitter_control[JITTER_BIT]};
            ADDR_STATUS:       next_rdata = {7'h00, FREQ_INVALID};
            ADDR_FREQ_LO:      next_rdata = FREQ_100KHZ[7:0];
            ADDR_FREQ_HI:      next_rdata = {2'h0, FREQ_100KHZ[FREQ_W-1:8]};
            default:           next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            REG_RDATA <= 8'h00;
        else if (CE && REG_RE)
            REG_RDATA <= next_rdata;
    end

    // ==========================================================
    // Carrier decode
    assign dec_if.band     = synth_band_reg[BAND_MSB:0];
    assign dec_if.number   = synth_number_reg;
    assign dec_if.std_chan = channel_cca_control[STD_CHAN_MSB:0]; // RQ14

    rfcfs_decode u_decode (
        .ifc (dec_if.dec)
    );

    // Synthesizer setting runs straight off the reference clock with no jitter path, so
    // a jitter change can never move the carrier
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            FREQ_100KHZ  <= '0; // RQ17
            FREQ_INVALID <= 1'b0;
        end
        else if (CE)
        begin
            FREQ_INVALID <= !dec_if.valid; // RQ16
            if (dec_if.valid)
                FREQ_100KHZ <= dec_if.freq; // RQ1
        end
    end

    // ==========================================================
    // Oscillator trim and jitter scope
    always_ff @(posedge CLK)
    begin
        if (RST)
            TRIM_CAP_FF <= '0;
        else if (CE)
            TRIM_CAP_FF <= TRIM_STEP_FF * TRIM_CAP_W'(oscillator_control_reg[TRIM_MSB:0]); // RQ2
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            RX_JITTER_EN <= 1'b0;
            IO_JITTER_EN <= 1'b0;
        end
        else if (CE)
        begin
            RX_JITTER_EN <= jitter_control[JITTER_BIT]; // RQ4
            IO_JITTER_EN <= jitter_control[JITTER_BIT]; // RQ4
        end
    end

    // ==========================================================
    // Checks
    logic [2:0] band_q;
    logic [7:0] num_q;
    logic [4:0] chan_q;
    assign band_q = synth_band_reg[BAND_MSB:0];
    assign num_q  = synth_number_reg;
    assign chan_q = channel_cca_control[STD_CHAN_MSB:0];

    a_reset_clear: assert property (@(posedge CLK) RST |=> FREQ_100KHZ == '0) // RQ17
        else $error("carrier not cleared by reset");
    a_trim_scale: assert property (@(posedge CLK) disable iff (RST) // RQ2
        CE |=> TRIM_CAP_FF == 13'(300 * $past(oscillator_control_reg[TRIM_MSB:0])))
        else $error("trim capacitance mismatch");
    // Jitter follows its control bit while an unchanged setting keeps the carrier still
    a_jitter_split: assert property (@(posedge CLK) disable iff (RST) // RQ4
        CE && $past(CE) && !$past(RST) && $stable(dec_if.freq) && $stable(dec_if.valid)
            |=> RX_JITTER_EN == $past(jitter_control[JITTER_BIT])
            && IO_JITTER_EN == $past(jitter_control[JITTER_BIT]) && $stable(FREQ_100KHZ))
        else $error("jitter scope wrong");
    // Both edges must follow a live band 0 setting, else a reset or frozen edge moves the carrier
    a_band0_ignore: assert property (@(posedge CLK) disable iff (RST) // RQ5
        CE && $past(CE) && !$past(RST) && band_q == 3'h0 && $past(band_q) == 3'h0 && $stable(chan_q)
            |=> $stable(FREQ_100KHZ))
        else $error("band 0 carrier moved with channel number");
    a_eu_channel: assert property (@(posedge CLK) disable iff (RST) // RQ6
        CE && band_q == 3'h0 && chan_q == 5'h00 |=> FREQ_100KHZ == 14'd8683)
        else $error("868.3 MHz not selected");
    a_na_channel: assert property (@(posedge CLK) disable iff (RST) // RQ7
        CE && band_q == 3'h0 && chan_q >= 5'h01 && chan_q <= 5'h0A
            |=> FREQ_100KHZ == 14'(9060 + 20 * ($past(chan_q) - 1)))
        else $error("north american channel wrong");
    a_band1_fine: assert property (@(posedge CLK) disable iff (RST) // RQ8
        CE && band_q == 3'h1 |=> FREQ_100KHZ == 14'(7690 + $past(num_q)))
        else $error("band 1 carrier wrong");
    a_band2_fine: assert property (@(posedge CLK) disable iff (RST) // RQ9
        CE && band_q == 3'h2 |=> FREQ_100KHZ == 14'(8570 + $past(num_q)))
        else $error("band 2 carrier wrong");
    a_band3_fine: assert property (@(posedge CLK) disable iff (RST) // RQ10
        CE && band_q == 3'h3 |=> FREQ_100KHZ == 14'(9030 + $past(num_q)))
        else $error("band 3 carrier wrong");
    a_band4_coarse: assert property (@(posedge CLK) disable iff (RST) // RQ11
        CE && band_q == 3'h4 |=> (FREQ_INVALID == ($past(num_q) > 8'h5E))
            && ($past(num_q) > 8'h5E || FREQ_100KHZ == 14'(7690 + 10 * $past(num_q))))
        else $error("band 4 carrier wrong");
    a_band5_coarse: assert property (@(posedge CLK) disable iff (RST) // RQ12
        CE && band_q == 3'h5 |=> (FREQ_INVALID == ($past(num_q) > 8'h66))
            && ($past(num_q) > 8'h66 || FREQ_100KHZ == 14'(8330 + 10 * $past(num_q))))
        else $error("band 5 carrier wrong");
    a_band6_fine: assert property (@(posedge CLK) disable iff (RST) // RQ13
        CE && band_q == 3'h6 |=> FREQ_100KHZ == 14'(9020 + $past(num_q)))
        else $error("band 6 carrier wrong");
    a_chan_field: assert property (@(posedge CLK) disable iff (RST) // RQ14
        wr_ok && REG_ADDR == 6'h08 |=> chan_q == $past(REG_WDATA[4:0]))
        else $error("standard channel field not stored");
    a_reserved_std: assert property (@(posedge CLK) disable iff (RST) // RQ15
        CE && band_q == 3'h0 && chan_q > 5'h0A |=> FREQ_INVALID)
        else $error("reserved channel not flagged");
    a_invalid_hold: assert property (@(posedge CLK) disable iff (RST) // RQ16
        CE && (band_q == 3'h7) |=> FREQ_INVALID && $stable(FREQ_100KHZ))
        else $error("invalid setting did not hold carrier");
    a_ce_freeze: assert property (@(posedge CLK) disable iff (RST) // RQ17
        !CE |=> $stable(FREQ_100KHZ) && $stable(FREQ_INVALID) && $stable(TRIM_CAP_FF)
            && $stable(RX_JITTER_EN) && $stable(REG_RDATA))
        else $error("outputs moved while clock enable low");
    a_chan_readback: assert property (@(posedge CLK) disable iff (RST) // RQ14
        CE && REG_RE && REG_ADDR == 6'h08 |=> REG_RDATA == $past(channel_cca_control))
        else $error("channel register read back wrong");
    a_status_read: assert property (@(posedge CLK) disable iff (RST) // RQ16
        CE && REG_RE && REG_ADDR == 6'h15 |=> REG_RDATA == {7'h00, $past(FREQ_INVALID)})
        else $error("status read back wrong");
endmodule : rfcfs_top
`default_nettype wire

// *** dv/rfcfs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Register-level bench for the channel and reference decoder
module testbench;
    import rfcfs_pkg::*;
    logic                  clk;
    logic                  rst;
    logic                  ce;
    rfcfs_addr_t           reg_addr;
    rfcfs_data_t           reg_wdata;
    logic                  reg_we;
    logic                  reg_re;
    rfcfs_data_t           reg_rdata;
    rfcfs_freq_t           freq_100khz;
    logic                  freq_invalid;
    logic [TRIM_CAP_W-1:0] trim_cap_ff;
    logic                  rx_jitter_en;
    logic                  io_jitter_en;
    int                    miscompares;
    int                    checked;
    rfcfs_freq_t           exp_f;
    logic                  exp_ok;
    logic [2:0]            m_band;
    logic [7:0]            m_num;
    logic [4:0]            m_std;
    rfcfs_data_t           rdat;
    logic [2:0]            fine_bands [4] = '{3'h1, 3'h2, 3'h3, 3'h6};

    rfcfs_top dut (.CLK(clk), .RST(rst), .CE(ce), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
                   .REG_WE(reg_we), .REG_RE(reg_re), .REG_RDATA(reg_rdata), .FREQ_100KHZ(freq_100khz),
                   .FREQ_INVALID(freq_invalid), .TRIM_CAP_FF(trim_cap_ff), .RX_JITTER_EN(rx_jitter_en),
                   .IO_JITTER_EN(io_jitter_en));

    // ==========================================================
    // Clock, checks and bus tasks
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
        checked++;
        if (seen !== expv)
        begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : chk

    // Two cycles per access so a strobe is never dropped and raised in one step
    task automatic wr(input rfcfs_addr_t a, input rfcfs_data_t d);
        reg_we = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1 reg_we = 1'b0;
        @(posedge clk);
        #1;
    endtask : wr

    task automatic rd(input rfcfs_addr_t a, output rfcfs_data_t d);
        reg_re = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1 reg_re = 1'b0;
        d = reg_rdata;
        @(posedge clk);
        #1;
    endtask : rd

    // Model follows every write, so intermediate valid settings move the held carrier too
    task automatic wreg(input rfcfs_addr_t a, input rfcfs_data_t d);
        rfcfs_freq_t f;
        if (a == ADDR_SYNTH_NUMBER) m_num = d;
        if (a == ADDR_SYNTH_BAND) m_band = d[2:0];
        if (a == ADDR_CHANNEL_CCA) m_std = d[4:0];
        exp_ok = 1'b1;
        case (m_band)
            3'h0:
            begin
                exp_ok = (m_std <= 5'h0A);
                f = (m_std == 5'h00) ? F_EU : F_NA_BASE + F_NA_STEP * 14'(m_std - 5'h01);
            end
            3'h1: f = F_BAND1 + 14'(m_num);
            3'h2: f = F_BAND2 + 14'(m_num);
            3'h3: f = F_BAND3 + 14'(m_num);
            3'h6: f = F_BAND6 + 14'(m_num);
            3'h4:
            begin
                exp_ok = (m_num <= 8'h5E);
                f = F_BAND4 + F_COARSE_STEP * 14'(m_num);
            end
            3'h5:
            begin
                exp_ok = (m_num <= 8'h66);
                f = F_BAND5 + F_COARSE_STEP * 14'(m_num);
            end
            default:
            begin
                exp_ok = 1'b0;
                f = 14'h0000;
            end
        endcase
        if (exp_ok) exp_f = f;
        wr(a, d);
    endtask : wreg

    // Upper bits of the channel register are set to show they do not steer the carrier
    task automatic apply(input logic [2:0] band, input logic [7:0] num, input logic [4:0] std);
        wreg(ADDR_SYNTH_NUMBER, num);
        wreg(ADDR_SYNTH_BAND, {5'h00, band});
        wreg(ADDR_CHANNEL_CCA, {3'h5, std});
        chk(16'(freq_100khz), 16'(exp_f));
        chk(16'(freq_invalid), 16'(!exp_ok));
    endtask : apply

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        miscompares = 0;
        checked = 0;
        rst = 1'b1;
        ce = 1'b1;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_we = 1'b0;
        reg_re = 1'b0;
        {m_band, m_num, m_std} = 16'h0000;
        exp_f = F_EU;
        repeat (5) @(posedge clk);
        #1 chk(16'(freq_100khz), 16'h0000);
        rst = 1'b0;
        @(posedge clk);
        #1 chk(16'(freq_100khz), 16'(F_EU));
        chk(16'(freq_invalid), 16'h0000);
        rd(ADDR_CHANNEL_CCA, rdat);
        chk(16'(rdat), 16'(RESET_REG));
        rd(6'h3F, rdat);
        chk(16'(rdat), 16'h0000);
        for (int c = 0; c < 16; c += 5)
        begin
            wr(ADDR_OSC_CTRL, 8'hA0 | 8'(c));
            chk(16'(trim_cap_ff), 16'(TRIM_STEP_FF * 13'(c)));
        end
        rd(ADDR_OSC_CTRL, rdat);
        chk(16'(rdat), 16'h00AF);
        wr(ADDR_JITTER_CTRL, 8'h01);
        chk(16'({rx_jitter_en, io_jitter_en}), 16'h0003);
        chk(16'(freq_100khz), 16'(F_EU));
        wr(ADDR_JITTER_CTRL, 8'h00);
        chk(16'({rx_jitter_en, io_jitter_en}), 16'h0000);
        for (int k = 0; k <= 10; k++)
            apply(3'h0, 8'h77 + 8'(k), 5'(k));
        apply(3'h0, 8'h00, 5'h0B);
        apply(3'h0, 8'h10, 5'h1F);
        foreach (fine_bands[i])
        begin
            apply(fine_bands[i], 8'h00, 5'h00);
            apply(fine_bands[i], 8'hFF, 5'h00);
        end
        apply(3'h4, 8'h5E, 5'h00);
        apply(3'h4, 8'h5F, 5'h00);
        apply(3'h5, 8'h66, 5'h00);
        apply(3'h5, 8'h67, 5'h00);
        apply(3'h7, 8'h10, 5'h00);
        rd(ADDR_STATUS, rdat);
        chk(16'(rdat), 16'h0001);
        rd(ADDR_FREQ_LO, rdat);
        chk(16'(rdat), 16'(exp_f[7:0]));
        rd(ADDR_FREQ_HI, rdat);
        chk(16'(rdat), 16'(exp_f[13:8]));
        apply(3'h2, 8'h05, 5'h00);
        wr(ADDR_STATUS, 8'hFF);
        rd(ADDR_STATUS, rdat);
        chk(16'(rdat), 16'h0000);
        ce = 1'b0;
        wr(ADDR_SYNTH_BAND, 8'h07);
        ce = 1'b1;
        chk(16'({freq_invalid, freq_100khz}), 16'(exp_f));
        rd(ADDR_SYNTH_BAND, rdat);
        chk(16'(rdat), 16'h0002);
        test_done();
    end
endmodule : testbench
`default_nettype wire
